// ---- hw/added_interrupt_status_enable.sv ----
// added interrupt status and enable registers with avalon-mm slave
//////////////////////////////////////////////////////////////////////
// What this block does
// - rx early flag sets when enabled, write-one clears
// - transceiver flag from OR of seven bits
// - added flags latch until one written
// - pause flag on pause frame while enabled
// - bus error kind field, read-only
// - transmit engine state, read-only field
// - receive engine state, read-only field
// - added normal summary on normal events
// - added abnormal summary on abnormal events
// - low fifteen status bits shared with primary
// - added enables read/write, reset zero
// - normal summary enable feeds primary normal summary
// - abnormal summary enable feeds primary abnormal summary, for transceiver and tx deferred events only
//////////////////////////////////////////////////////////////////////
//
// Our own choice: the Avalon-MM interface to the registers.
module added_interrupt_status_enable (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// avalon-mm slave
	input wire logic [added_irq_pkg::ADDR_W-1:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [added_irq_pkg::DATA_W-1:0] writedata,
	input wire logic [added_irq_pkg::BE_W-1:0] byteenable,
	output logic [added_irq_pkg::DATA_W-1:0] readdata,
	output logic waitrequest,
	// added events, one-cycle pulses; pauseEnabled and transceiverIntBits are levels
	input wire logic txEarlyEvent,
	input wire logic rxEarlyEvent,
	input wire logic txDeferredEvent,
	input wire logic pauseFrameEvent,
	input wire logic pauseEnabled,
	input wire logic [added_irq_pkg::XCVR_SRC_W-1:0] transceiverIntBits,
	// primary events, one-cycle pulses
	input wire logic [added_irq_pkg::SHARED_W-1:0] primaryEvent,
	input wire logic primaryNormalEvent,
	input wire logic primaryAbnormalEvent,
	// engine reports, levels
	input wire logic [added_irq_pkg::FIELD_W-1:0] busErrorKindIn,
	input wire logic [added_irq_pkg::FIELD_W-1:0] txEngineStateIn,
	input wire logic [added_irq_pkg::FIELD_W-1:0] rxEngineStateIn,
	// interrupt
	output logic irq
);
	//////////////////////////////////////////////////////////////////
	// helpers

	function automatic logic [31:0] laneMask(input logic [3:0] be);
		logic [31:0] m;
		m = 32'h0000_0000;
		for (int i = 0; i < 4; i++) begin
			m[i*8 +: 8] = {8{be[i]}};
		end
		return m;
	endfunction : laneMask

	// set wins over clear so a same-cycle event is kept
	function automatic logic sticky(input logic cur, input logic set, input logic clr);
		return set | (cur & ~clr);
	endfunction : sticky

	//////////////////////////////////////////////////////////////////
	// bus handshake

	logic accept, writeAccept, readAccept;
	logic [31:0] wMask, clrBits, readValue;
	logic hitPrimStat, hitPrimEn, hitAddStat, hitAddEn, hitIrqStat, hitIrqMask;

	assign accept = (read | write) & ~waitrequest;
	assign writeAccept = accept & write;
	assign readAccept = accept & read;
	assign wMask = laneMask(byteenable);
	assign clrBits = writedata & wMask;
	assign hitPrimStat = (address == added_irq_pkg::PRIMARY_STATUS_ADDR);
	assign hitPrimEn = (address == added_irq_pkg::PRIMARY_ENABLE_ADDR);
	assign hitAddStat = (address == added_irq_pkg::ADDED_STATUS_ADDR);
	assign hitAddEn = (address == added_irq_pkg::ADDED_ENABLE_ADDR);
	assign hitIrqStat = (address == added_irq_pkg::IRQ_STATUS_ADDR);
	assign hitIrqMask = (address == added_irq_pkg::IRQ_MASK_ADDR);

	// one wait cycle per access; read data is captured in it
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			waitrequest <= 1'b1;
		end else if (accept) begin
			waitrequest <= 1'b1;
		end else if (read | write) begin
			waitrequest <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			readdata <= 32'h0000_0000;
		end else if (read & waitrequest) begin
			readdata <= readValue;
		end
	end

	//////////////////////////////////////////////////////////////////
	// added flags

	logic txEarlyFlag, rxEarlyFlag, transceiverFlag, txDeferredFlag, pauseReceivedFlag;
	logic addedNormalSummary, addedAbnormalSummary;
	logic txEarlyEnable, rxEarlyEnable, transceiverEnable, txDeferredEnable, pauseReceivedEnable;
	logic addedNormalSummaryEnable, addedAbnormalSummaryEnable;
	logic setTxEarly, setRxEarly, setXcvr, setTxDefer, setPause, normalHit, abnormalHit, addClr;

	assign setTxEarly = txEarlyEvent & txEarlyEnable;
	assign setRxEarly = rxEarlyEvent & rxEarlyEnable;
	assign setXcvr = |transceiverIntBits;
	assign setTxDefer = txDeferredEvent;
	assign setPause = pauseFrameEvent & pauseEnabled;
	assign normalHit = setTxEarly | setRxEarly;
	assign abnormalHit = setXcvr | setTxDefer | setPause;
	assign addClr = writeAccept & hitAddStat;

	// only a one written to a flag clears it
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			txEarlyFlag <= 1'b0;
			rxEarlyFlag <= 1'b0;
			transceiverFlag <= added_irq_pkg::XCVR_RESET;
			txDeferredFlag <= 1'b0;
			pauseReceivedFlag <= 1'b0;
		end else begin
			txEarlyFlag <= sticky(txEarlyFlag, setTxEarly,
				addClr & clrBits[added_irq_pkg::TX_EARLY_BIT]);
			rxEarlyFlag <= sticky(rxEarlyFlag, setRxEarly,
				addClr & clrBits[added_irq_pkg::RX_EARLY_BIT]);
			transceiverFlag <= sticky(transceiverFlag, setXcvr,
				addClr & clrBits[added_irq_pkg::XCVR_BIT]);
			txDeferredFlag <= sticky(txDeferredFlag, setTxDefer,
				addClr & clrBits[added_irq_pkg::TX_DEFER_BIT]);
			pauseReceivedFlag <= sticky(pauseReceivedFlag, setPause,
				addClr & clrBits[added_irq_pkg::PAUSE_BIT]);
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			addedNormalSummary <= 1'b0;
			addedAbnormalSummary <= added_irq_pkg::ABNORMAL_SUM_RESET;
		end else begin
			addedNormalSummary <= sticky(addedNormalSummary, normalHit,
				addClr & clrBits[added_irq_pkg::NORMAL_SUM_BIT]);
			addedAbnormalSummary <= sticky(addedAbnormalSummary, abnormalHit,
				addClr & clrBits[added_irq_pkg::ABNORMAL_SUM_BIT]);
		end
	end

	//////////////////////////////////////////////////////////////////
	// added enables

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			txEarlyEnable <= 1'b0;
			rxEarlyEnable <= 1'b0;
			transceiverEnable <= 1'b0;
			txDeferredEnable <= 1'b0;
			pauseReceivedEnable <= 1'b0;
			addedNormalSummaryEnable <= 1'b0;
			addedAbnormalSummaryEnable <= 1'b0;
		end else if (writeAccept & hitAddEn) begin
			// reserved bits are simply not stored
			if (byteenable[3]) begin
				txEarlyEnable <= writedata[added_irq_pkg::TX_EARLY_BIT];
				rxEarlyEnable <= writedata[added_irq_pkg::RX_EARLY_BIT];
				transceiverEnable <= writedata[added_irq_pkg::XCVR_BIT];
				txDeferredEnable <= writedata[added_irq_pkg::TX_DEFER_BIT];
				pauseReceivedEnable <= writedata[added_irq_pkg::PAUSE_BIT];
			end
			if (byteenable[2]) begin
				addedNormalSummaryEnable <= writedata[added_irq_pkg::NORMAL_SUM_BIT];
			end
			if (byteenable[1]) begin
				addedAbnormalSummaryEnable <= writedata[added_irq_pkg::ABNORMAL_SUM_BIT];
			end
		end
	end

	//////////////////////////////////////////////////////////////////
	// shared primary storage

	logic [added_irq_pkg::SHARED_W-1:0] sharedStatus, sharedEnable;
	logic primaryNormalSummary, primaryAbnormalSummary, primaryNormalEnable, primaryAbnormalEnable;
	logic statClr, primClr, enWrite;
	logic [31:0] enData;

	// both addresses reach one set of flip-flops
	assign statClr = writeAccept & (hitAddStat | hitPrimStat);
	assign primClr = writeAccept & hitPrimStat;
	assign enWrite = writeAccept & (hitAddEn | hitPrimEn);
	assign enData = writedata & wMask;

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			sharedStatus <= '0;
		end else begin
			for (int i = 0; i < added_irq_pkg::SHARED_W; i++) begin
				sharedStatus[i] <= sticky(sharedStatus[i], primaryEvent[i],
					statClr & clrBits[i]);
			end
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			sharedEnable <= '0;
		end else if (enWrite) begin
			sharedEnable <= (sharedEnable & ~wMask[added_irq_pkg::SHARED_W-1:0])
				| enData[added_irq_pkg::SHARED_W-1:0];
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			primaryNormalEnable <= 1'b0;
			primaryAbnormalEnable <= 1'b0;
		end else if (writeAccept & hitPrimEn) begin
			if (byteenable[2]) begin
				primaryNormalEnable <= writedata[added_irq_pkg::NORMAL_SUM_BIT];
			end
			if (byteenable[1]) begin
				primaryAbnormalEnable <= writedata[added_irq_pkg::ABNORMAL_SUM_BIT];
			end
		end
	end

	// added events reach the primary summaries only when enabled
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			primaryNormalSummary <= 1'b0;
		end else begin
			primaryNormalSummary <= sticky(primaryNormalSummary,
				primaryNormalEvent | (addedNormalSummaryEnable & normalHit),
				primClr & clrBits[added_irq_pkg::NORMAL_SUM_BIT]);
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			primaryAbnormalSummary <= 1'b0;
		end else begin
			primaryAbnormalSummary <= sticky(primaryAbnormalSummary,
				primaryAbnormalEvent | (addedAbnormalSummaryEnable & (setXcvr | setTxDefer)),
				primClr & clrBits[added_irq_pkg::ABNORMAL_SUM_BIT]);
		end
	end

	//////////////////////////////////////////////////////////////////
	// read-only fields

	logic [added_irq_pkg::FIELD_W-1:0] busErrorKind, txEngineState, rxEngineState;

	// kind is caught with the fatal bus error, so it stays valid while the flag stands
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			busErrorKind <= added_irq_pkg::BUS_ERR_PARITY;
		end else if (primaryEvent[added_irq_pkg::FATAL_BUS_BIT]) begin
			busErrorKind <= busErrorKindIn;
		end
	end

	// sampled each cycle; bus writes never reach these
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			txEngineState <= added_irq_pkg::TX_STOP;
			rxEngineState <= added_irq_pkg::RX_STOP;
		end else begin
			txEngineState <= txEngineStateIn;
			rxEngineState <= rxEngineStateIn;
		end
	end

	//////////////////////////////////////////////////////////////////
	// sticky interrupt status, mask and line

	logic [added_irq_pkg::IRQ_W-1:0] irqStatus, irqMask, irqSet, irqClr;

	always_comb begin
		irqSet = '0;
		irqSet[added_irq_pkg::IRQ_TX_EARLY] = setTxEarly;
		irqSet[added_irq_pkg::IRQ_RX_EARLY] = setRxEarly;
		irqSet[added_irq_pkg::IRQ_XCVR] = setXcvr & transceiverEnable;
		irqSet[added_irq_pkg::IRQ_TX_DEFER] = setTxDefer & txDeferredEnable;
		irqSet[added_irq_pkg::IRQ_PAUSE] = setPause & pauseReceivedEnable;
	end

	// clear only what the read returned, so a later set is not lost
	assign irqClr = (readAccept & hitIrqStat) ? readdata[added_irq_pkg::IRQ_W-1:0] : '0;

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			irqStatus <= '0;
		end else begin
			irqStatus <= irqSet | (irqStatus & ~irqClr);
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			irqMask <= '0;
		end else if (writeAccept & hitIrqMask & byteenable[0]) begin
			irqMask <= writedata[added_irq_pkg::IRQ_W-1:0];
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			irq <= 1'b0;
		end else begin
			irq <= |((irqSet | (irqStatus & ~irqClr)) & irqMask);
		end
	end

	//////////////////////////////////////////////////////////////////
	// read mux

	always_comb begin
		readValue = 32'h0000_0000;
		if (hitAddStat) begin
			readValue[added_irq_pkg::TX_EARLY_BIT] = txEarlyFlag;
			readValue[added_irq_pkg::RX_EARLY_BIT] = rxEarlyFlag;
			readValue[added_irq_pkg::XCVR_BIT] = transceiverFlag;
			readValue[added_irq_pkg::TX_DEFER_BIT] = txDeferredFlag;
			readValue[added_irq_pkg::PAUSE_BIT] = pauseReceivedFlag;
			readValue[added_irq_pkg::BUS_ERR_LSB +: added_irq_pkg::FIELD_W] = busErrorKind;
			readValue[added_irq_pkg::TX_STATE_LSB +: added_irq_pkg::FIELD_W] = txEngineState;
			readValue[added_irq_pkg::RX_STATE_LSB +: added_irq_pkg::FIELD_W] = rxEngineState;
			readValue[added_irq_pkg::NORMAL_SUM_BIT] = addedNormalSummary;
			readValue[added_irq_pkg::ABNORMAL_SUM_BIT] = addedAbnormalSummary;
			readValue[added_irq_pkg::SHARED_W-1:0] = sharedStatus;
		end else if (hitAddEn) begin
			readValue[added_irq_pkg::TX_EARLY_BIT] = txEarlyEnable;
			readValue[added_irq_pkg::RX_EARLY_BIT] = rxEarlyEnable;
			readValue[added_irq_pkg::XCVR_BIT] = transceiverEnable;
			readValue[added_irq_pkg::TX_DEFER_BIT] = txDeferredEnable;
			readValue[added_irq_pkg::PAUSE_BIT] = pauseReceivedEnable;
			readValue[added_irq_pkg::NORMAL_SUM_BIT] = addedNormalSummaryEnable;
			readValue[added_irq_pkg::ABNORMAL_SUM_BIT] = addedAbnormalSummaryEnable;
			readValue[added_irq_pkg::SHARED_W-1:0] = sharedEnable;
		end else if (hitPrimStat) begin
			readValue[added_irq_pkg::NORMAL_SUM_BIT] = primaryNormalSummary;
			readValue[added_irq_pkg::ABNORMAL_SUM_BIT] = primaryAbnormalSummary;
			readValue[added_irq_pkg::SHARED_W-1:0] = sharedStatus;
		end else if (hitPrimEn) begin
			readValue[added_irq_pkg::NORMAL_SUM_BIT] = primaryNormalEnable;
			readValue[added_irq_pkg::ABNORMAL_SUM_BIT] = primaryAbnormalEnable;
			readValue[added_irq_pkg::SHARED_W-1:0] = sharedEnable;
		end else if (hitIrqStat) begin
			readValue[added_irq_pkg::IRQ_W-1:0] = irqStatus;
		end else if (hitIrqMask) begin
			readValue[added_irq_pkg::IRQ_W-1:0] = irqMask;
		end
	end
endmodule : added_interrupt_status_enable

// ---- hw/added_irq_pkg.sv ----
// constants for the added interrupt status and enable block
package added_irq_pkg;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int BE_W = 4;
	// register byte addresses
	localparam logic [7:0] PRIMARY_STATUS_ADDR = 8'h28;
	localparam logic [7:0] PRIMARY_ENABLE_ADDR = 8'h38;
	localparam logic [7:0] ADDED_STATUS_ADDR = 8'h80;
	localparam logic [7:0] ADDED_ENABLE_ADDR = 8'h84;
	localparam logic [7:0] IRQ_STATUS_ADDR = 8'hC0;
	localparam logic [7:0] IRQ_MASK_ADDR = 8'hC4;
	// added status and enable bit positions
	localparam int TX_EARLY_BIT = 31;
	localparam int RX_EARLY_BIT = 30;
	localparam int XCVR_BIT = 29;
	localparam int TX_DEFER_BIT = 28;
	localparam int PAUSE_BIT = 26;
	localparam int BUS_ERR_LSB = 23;
	localparam int TX_STATE_LSB = 20;
	localparam int RX_STATE_LSB = 17;
	localparam int NORMAL_SUM_BIT = 16;
	localparam int ABNORMAL_SUM_BIT = 15;
	localparam int SHARED_W = 15;
	localparam int FATAL_BUS_BIT = 13;
	localparam int FIELD_W = 3;
	localparam int XCVR_SRC_W = 7;
	// sticky interrupt register layout
	localparam int IRQ_W = 5;
	localparam int IRQ_TX_EARLY = 0;
	localparam int IRQ_RX_EARLY = 1;
	localparam int IRQ_XCVR = 2;
	localparam int IRQ_TX_DEFER = 3;
	localparam int IRQ_PAUSE = 4;
	// reset values of the flags that come up set
	localparam logic XCVR_RESET = 1'b1;
	localparam logic ABNORMAL_SUM_RESET = 1'b1;
	// bus error kinds
	localparam logic [2:0] BUS_ERR_PARITY = 3'h0;
	localparam logic [2:0] BUS_ERR_MASTER_ABORT = 3'h1;
	localparam logic [2:0] BUS_ERR_TARGET_ABORT = 3'h2;
	// transmit engine codes
	localparam logic [2:0] TX_STOP = 3'h0;
	localparam logic [2:0] TX_READ_DESC = 3'h1;
	localparam logic [2:0] TX_SENDING = 3'h2;
	localparam logic [2:0] TX_FIFO_FILL = 3'h3;
	localparam logic [2:0] TX_SUSPENDED = 3'h6;
	localparam logic [2:0] TX_WRITE_DESC = 3'h7;
	// receive engine codes
	localparam logic [2:0] RX_STOP = 3'h0;
	localparam logic [2:0] RX_READ_DESC = 3'h1;
	localparam logic [2:0] RX_CHECK = 3'h2;
	localparam logic [2:0] RX_WAIT = 3'h3;
	localparam logic [2:0] RX_SUSPENDED = 3'h4;
	localparam logic [2:0] RX_WRITE_DESC = 3'h5;
	localparam logic [2:0] RX_FLUSH = 3'h6;
	localparam logic [2:0] RX_DRAIN = 3'h7;
endpackage : added_irq_pkg

// ---- test/added_interrupt_status_enable_bench.sv ----
// self-checking bench for the added interrupt status and enable block
module added_interrupt_status_enable_bench;
	timeunit 1ns;
	timeprecision 1ns;
	logic sys_clk = 1'b0, rst = 1'b1, read = 1'b0, write = 1'b0, pauseOn = 1'b0, waitrequest, irq;
	logic [7:0] address = 8'h00;
	logic [31:0] writedata = 32'h0000_0000, readdata, rdv, v;
	logic [3:0] byteenable = 4'h0, ev = 4'h0;
	logic [6:0] xcvrBits = 7'h00;
	logic [14:0] pev = 15'h0000;
	logic [1:0] sumEv = 2'h0, mPri;
	logic [2:0] busKind = 3'h0, txState = 3'h0, rxState = 3'h0;
	// register model; FLAGS marks the bits a write may touch
	logic [31:0] mStat, mEn;
	logic [4:0] mIrq, mMask;
	int num_errors = 0, compares = 0;
	integer seed = 32'h8ae4;
	localparam logic [31:0] FLAGS = 32'hF401_FFFF;
	always #50 sys_clk = ~sys_clk;
	added_interrupt_status_enable dut (.sys_clk(sys_clk), .rst(rst), .address(address), .read(read), .write(write),
		.writedata(writedata), .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
		.txEarlyEvent(ev[0]), .rxEarlyEvent(ev[1]), .txDeferredEvent(ev[2]), .pauseFrameEvent(ev[3]),
		.pauseEnabled(pauseOn), .transceiverIntBits(xcvrBits), .primaryEvent(pev), .primaryNormalEvent(sumEv[1]),
		.primaryAbnormalEvent(sumEv[0]), .busErrorKindIn(busKind), .txEngineStateIn(txState),
		.rxEngineStateIn(rxState), .irq(irq));
	////////////////////////////////////////
	task automatic conclude;
		if (num_errors == 0 && compares > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : conclude
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			num_errors++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask : check
	// an idle cycle follows each access so no strobe is driven twice in one step
	task automatic bus(input logic rd, input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
		int n;
		n = 0;
		address <= a;
		read <= rd;
		write <= !rd;
		writedata <= d;
		byteenable <= be;
		do begin
			@(posedge sys_clk);
			n++;
		end while (waitrequest !== 1'b0 && n < 20);
		if (waitrequest !== 1'b0) begin
			num_errors++;
			conclude();
		end
		rdv = readdata;
		read <= 1'b0;
		write <= 1'b0;
		@(posedge sys_clk);
	endtask : bus
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] be = 4'hF);
		logic [31:0] l;
		l = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
		bus(1'b0, a, d, be);
		case (a)
			8'h80: mStat = mStat & ~(l & d & FLAGS);
			8'h28: begin
				mStat[14:0] = mStat[14:0] & ~(l[14:0] & d[14:0]);
				mPri = mPri & ~(l[16:15] & d[16:15]);
			end
			8'h84: mEn = (mEn & ~(l & FLAGS)) | (l & d & FLAGS);
			8'h38: mEn[14:0] = (mEn[14:0] & ~l[14:0]) | (l[14:0] & d[14:0]);
			8'hC4: mMask = be[0] ? d[4:0] : mMask;
			default: ;
		endcase
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] msk = 32'hFFFF_FFFF);
		logic [31:0] e;
		bus(1'b1, a, 32'h0000_0000, 4'h0);
		case (a)
			8'h80: e = mStat;
			8'h84: e = mEn;
			8'h28: e = {15'h0000, mPri, mStat[14:0]};
			8'hC0: e = {27'h000_0000, mIrq};
			8'hC4: e = {27'h000_0000, mMask};
			default: e = 32'h0000_0000;
		endcase
		check(rdv & msk, e & msk);
		if (a == 8'hC0) mIrq = 5'h00;
	endtask : rd
	task automatic fire(input int k);
		ev[k] <= 1'b1;
		@(posedge sys_clk);
		ev[k] <= 1'b0;
		repeat (2) @(posedge sys_clk);
		case (k)
			0, 1: if (mEn[31 - k]) begin
				mStat[31 - k] = 1'b1;
				mStat[16] = 1'b1;
				mIrq[k] = 1'b1;
				mPri[1] = mPri[1] | mEn[16];
			end
			2: begin
				mStat[28] = 1'b1;
				mStat[15] = 1'b1;
				mIrq[3] = mIrq[3] | mEn[28];
				mPri[0] = mPri[0] | mEn[15];
			end
			default: if (pauseOn) begin
				mStat[26] = 1'b1;
				mStat[15] = 1'b1;
				mIrq[4] = mIrq[4] | mEn[26];
			end
		endcase
	endtask : fire
	task automatic chk_irq;
		@(posedge sys_clk);
		check({31'h0000_0000, irq}, {31'h0000_0000, |(mIrq & mMask)});
	endtask : chk_irq
	////////////////////////////////////////
	initial begin
		repeat (4) @(posedge sys_clk);
		rst <= 1'b0;
		{mStat, mEn, mPri, mIrq, mMask} = {32'h2000_8000, 32'h0000_0000, 2'h0, 5'h00, 5'h00};
		@(posedge sys_clk);
		rd(8'h80);
		rd(8'h84);
		rd(8'hC4);
		rd(8'h44);
		wr(8'h80, 32'h03FE_0000);
		rd(8'h80);
		fire(0);
		rd(8'h80, 32'h8000_0000);
		wr(8'h80, 32'hFFFF_FFFF);
		wr(8'h28, 32'h0001_8000);
		rd(8'h80);
		rd(8'h28);
		wr(8'h84, 32'hFFFF_FFFF, 4'h3);
		rd(8'h84);
		v = $random(seed);
		wr(8'h84, v);
		rd(8'h84);
		v = $random(seed);
		wr(8'h38, v, 4'h3);
		rd(8'h84);
		for (int i = 0; i < 8; i++) begin
			txState <= i[2:0];
			rxState <= 3'h7 - i[2:0];
			mStat[22:17] = {i[2:0], 3'h7 - i[2:0]};
			repeat (4) @(posedge sys_clk);
			rd(8'h80);
		end
		// the kind input moves away after capture; the field must hold
		for (int k = 0; k < 3; k++) begin
			busKind <= k[2:0];
			pev <= 15'h2000;
			@(posedge sys_clk);
			pev <= 15'h0000;
			busKind <= 3'h7;
			repeat (2) @(posedge sys_clk);
			{mStat[25:23], mStat[13]} = {k[2:0], 1'b1};
			rd(8'h80);
			wr(8'h28, 32'h0000_2000);
		end
		v = $random(seed) & 32'h0000_5FFF;
		pev <= v[14:0];
		sumEv <= 2'h3;
		@(posedge sys_clk);
		pev <= 15'h0000;
		sumEv <= 2'h0;
		@(posedge sys_clk);
		{mStat[14:0], mPri} = {mStat[14:0] | v[14:0], 2'h3};
		rd(8'h28);
		wr(8'h80, v);
		rd(8'h80);
		wr(8'h28, 32'h0001_8000);
		wr(8'h84, 32'hF401_8000);
		wr(8'hC4, 32'h0000_001F);
		fire(0);
		chk_irq();
		fire(1);
		fire(2);
		rd(8'h80);
		rd(8'h28);
		rd(8'hC0);
		chk_irq();
		wr(8'hC4, 32'h0000_0000);
		fire(0);
		chk_irq();
		wr(8'hC4, 32'h0000_001F);
		chk_irq();
		rd(8'hC0);
		xcvrBits <= v[6:0] | 7'h01;
		repeat (4) @(posedge sys_clk);
		{mStat[29], mStat[15], mIrq[2], mPri[0]} = 4'hF;
		rd(8'h80);
		xcvrBits <= 7'h00;
		wr(8'h80, 32'h2000_0000);
		rd(8'h80);
		rd(8'hC0);
		fire(3);
		rd(8'h80, 32'h0400_0000);
		pauseOn <= 1'b1;
		fire(3);
		rd(8'h80);
		rd(8'hC0);
		conclude();
	end
	initial begin
		repeat (20000) @(posedge sys_clk);
		num_errors++;
		conclude();
	end
endmodule : added_interrupt_status_enable_bench

// ---- test/added_interrupt_status_enable_sva.sv ----
// port assertions for the added interrupt status and enable block
module added_interrupt_status_enable_sva (
	// clock, reset and avalon-mm slave
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic [7:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] readdata,
	input wire logic waitrequest,
	// events and engine levels
	input wire logic txEarlyEvent,
	input wire logic rxEarlyEvent,
	input wire logic txDeferredEvent,
	input wire logic pauseFrameEvent,
	input wire logic [6:0] transceiverIntBits,
	input wire logic [14:0] primaryEvent,
	input wire logic [2:0] busErrorKindIn,
	input wire logic [2:0] txEngineStateIn,
	input wire logic [2:0] rxEngineStateIn,
	// interrupt
	input wire logic irq
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	logic [2:0] lastKind;
	logic irqTouch, anyEvent;
	// only an irq status read or a mask write may pull irq down
	assign irqTouch = !waitrequest && ((read && address == 8'hC0) || (write && address == 8'hC4));
	assign anyEvent = txEarlyEvent | rxEarlyEvent | txDeferredEvent | pauseFrameEvent | (|transceiverIntBits);
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			lastKind <= 3'h0;
		end else if (primaryEvent[13]) begin
			lastKind <= busErrorKindIn;
		end
	end
	////////////////////////////////////////
	sequence s_request_start;
		$rose(read || write);
	endsequence
	sequence s_read_at(a);
		!waitrequest && read && address == a;
	endsequence
	a_wait_single: assert property ($fell(waitrequest) |=> waitrequest)
		else $error("waitrequest low too long");
	a_wait_answer: assert property (s_request_start |-> ##[1:2] !waitrequest)
		else $error("access not answered");
	a_unmapped_zero: assert property (!waitrequest && read &&
		!(address inside {8'h28, 8'h38, 8'h80, 8'h84, 8'hC0, 8'hC4}) |-> readdata == 32'h0000_0000)
		else $error("unmapped read not zero");
	a_enable_reserved: assert property (s_read_at(8'h84) |-> readdata[27] == 1'b0 && readdata[25:17] == 9'h000)
		else $error("reserved enable bits set");
	a_engine_fields: assert property ($stable({txEngineStateIn, rxEngineStateIn}) [*4] ##0 s_read_at(8'h80)
		|-> readdata[22:17] == {txEngineStateIn, rxEngineStateIn}) else $error("engine field wrong");
	a_xcvr_flag: assert property ((transceiverIntBits != 7'h00) [*4] ##0 s_read_at(8'h80) |-> readdata[29])
		else $error("transceiver flag clear");
	a_bus_kind: assert property (!$past(primaryEvent[13]) && !waitrequest && read && address == 8'h80
		|-> readdata[25:23] == lastKind) else $error("bus error kind wrong");
	a_irq_rise: assert property ($rose(irq) |-> $past(anyEvent) || $past(anyEvent, 2) || $past(irqTouch)
		|| $past(irqTouch, 2)) else $error("irq rose without cause");
	a_irq_fall: assert property ($fell(irq) |-> $past(irqTouch) || $past(irqTouch, 2))
		else $error("irq fell without clear");
endmodule : added_interrupt_status_enable_sva

bind added_interrupt_status_enable added_interrupt_status_enable_sva u_sva (.sys_clk(sys_clk), .rst(rst),
	.address(address), .read(read), .write(write), .readdata(readdata), .waitrequest(waitrequest),
	.txEarlyEvent(txEarlyEvent), .rxEarlyEvent(rxEarlyEvent), .txDeferredEvent(txDeferredEvent),
	.pauseFrameEvent(pauseFrameEvent), .transceiverIntBits(transceiverIntBits), .primaryEvent(primaryEvent),
	.busErrorKindIn(busErrorKindIn), .txEngineStateIn(txEngineStateIn), .rxEngineStateIn(rxEngineStateIn),
	.irq(irq));
